/* File: core/adc_config_register_control.sv */
// Functional notes
// RULE1 - Host writes zero to unused bits
// RULE2 - Power-down bit with kind selects save mode
// RULE3 - Save modes power analog down, halt filter
// RULE4 - Standby keeps oscillator and bias running
// RULE5 - Leaving sleep waits oscillator start-up unless external
// RULE6 - Reset request bit resets internal logic
// RULE7 - Reset sets done flag; read clears it
// RULE8 - Reset loads documented default register values
// RULE9 - Host writes reset bit back to zero
// RULE10 - After reset cycle, return to command mode
// RULE11 - Reset write sets only the reset bit
// RULE12 - Input short disconnects and shorts inputs
// RULE13 - Guard drives low pin, ignores source select
// RULE14 - Reference range bit sizes sampling capacitor
// RULE15 - Source select picks setup or configuration latches
// RULE16 - Configuration latches drive pins on command execution
// RULE17 - Calibration set from channel or pointer
// RULE18 - Rate scale bit scales word rates by five-sixths
// RULE19 - Word rates scale with master clock
// RULE20 - Setup latch bits drive pins on execution
// RULE21 - Host accesses register with 32 data bits
// RULE22 - Done flag ignores writes, reads before clearing
`timescale 1ns/100ps
`default_nettype none

module adc_config_register_control
    import adc_cfg_pkg::*;
#(
    parameter int unsigned OSC_STARTUP = adc_cfg_pkg::OSC_STARTUP_CYCLES
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    input  wire logic                       cfg_write,
    input  wire logic [31:0]                cfg_write_data,
    input  wire logic                       cfg_read,
    output logic      [31:0]                cfg_read_data,
    input  wire logic                       cmd_execute,
    input  wire adc_cfg_pkg::setup_fields_s setup,
    input  wire logic                       external_clock,
    output adc_cfg_pkg::power_state_e       power_state,
    output adc_cfg_pkg::analog_ctrl_s       analog_ctrl,
    output logic                            system_reset,
    output logic                            command_ready,
    output logic                            reset_done_flag,
    output logic                            latch_pin_low,
    output logic                            latch_pin_high,
    output logic      [1:0]                 calibration_index,
    output logic      [19:0]                word_period
);

    import adc_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release synchroniser; entry stays immediate, release
    // waits two edges so no flop leaves reset on a marginal edge

    logic [1:0] rst_pipe;
    logic       rst_sync_b;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////
    // State

    // Every register of the block except the reset pipe and the start-up timer, loaded on each edge
    typedef struct packed {
        logic [31:0]  cfg;
        logic [31:0]  read_data;
        power_state_e pwr;
        logic         latch_low;
        logic         latch_high;
        logic         sys_reset;
        logic         wake_start;
        logic         ext_meta;
        logic         ext_sync;
        logic [1:0]   cal_index;
        logic [19:0]  period;
    } ctrl_state_s;

    // Power-on values; the period is that of rate code 12
    localparam ctrl_state_s STATE_RESET = '{
        cfg:        CONFIG_RESET,
        read_data:  CONFIG_RESET,
        pwr:        PWR_NORMAL,
        latch_low:  1'b0,
        latch_high: 1'b0,
        sys_reset:  1'b0,
        wake_start: 1'b0,
        ext_meta:   1'b0,
        ext_sync:   1'b0,
        cal_index:  2'h0,
        period:     FAST_PERIOD_NORMAL << 4
    };

    ctrl_state_s cur;
    ctrl_state_s next_cur;
    logic        wake_done;
    logic        reset_write;

    // A reset write overrides a command execute of the same cycle
    assign reset_write = cfg_write &&
                         cfg_write_data[SYSTEM_RESET_REQUEST_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Word period in master clock cycles; a period counted in clock
    // cycles makes every rate follow the actual clock frequency.

    function automatic logic [19:0] rate_period(
        input logic [3:0] code,
        input logic       scaled
    );
        logic [19:0] base;
        // Unused codes give a zero period
        base = 20'h00000;
        if (code <= RATE_CODE_SLOW_MAX) begin
            base = scaled ? SLOW_PERIOD_SCALED : SLOW_PERIOD_NORMAL;
            base = base << code[2:0];
        end else if (code >= RATE_CODE_FAST_MIN &&
                     code <= RATE_CODE_FAST_MAX) begin
            base = scaled ? FAST_PERIOD_SCALED : FAST_PERIOD_NORMAL;
            base = base << code[2:0];
        end
        return base;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_cur            = cur;
        next_cur.sys_reset  = 1'b0;
        next_cur.wake_start = 1'b0;
        // External clock pin passes two flops before use
        next_cur.ext_meta   = external_clock;
        next_cur.ext_sync   = cur.ext_meta;

        // Read returns the word including the flag, then clears it;
        // the data holds until the next read, and a write in the
        // same cycle is not yet visible in it
        if (cfg_read) begin
            next_cur.read_data = cur.cfg;                         // [RULE22]
            next_cur.cfg[RESET_DONE_FLAG_BIT] = 1'b0;             // [RULE7]
        end

        // Whole words only; the serial side assembles all 32 bits
        if (cfg_write) begin                                      // [RULE21]
            if (cfg_write_data[SYSTEM_RESET_REQUEST_BIT]) begin
                // Only the request bit lands; everything else defaults
                next_cur.cfg = CONFIG_RESET;                      // [RULE8]
                next_cur.cfg[SYSTEM_RESET_REQUEST_BIT] = 1'b1;    // [RULE11]
                // Set wins over a read that clears in the same cycle
                next_cur.cfg[RESET_DONE_FLAG_BIT] = 1'b1;         // [RULE7]
                next_cur.sys_reset  = 1'b1;                       // [RULE6]
                next_cur.latch_low  = 1'b0;
                next_cur.latch_high = 1'b0;
            end else if (cur.cfg[SYSTEM_RESET_REQUEST_BIT]) begin
                // Clearing write completes the cycle, other bits wait
                next_cur.cfg[SYSTEM_RESET_REQUEST_BIT] = 1'b0;    // [RULE9]
            end else begin
                // Flag and reserved bits are never taken from the host
                next_cur.cfg = (cfg_write_data & CONFIG_WRITE_MASK) |
                    (next_cur.cfg & ~CONFIG_WRITE_MASK);          // [RULE1]
            end
        end

        // Latch pins update when a command executes and clear on a reset
        // write, which wins over a command execute in the same cycle
        if (cmd_execute && !reset_write &&
            !cur.cfg[SYSTEM_RESET_REQUEST_BIT]) begin
            if (cur.cfg[LATCH_SOURCE_SELECT_BIT] &&
                !cur.cfg[GUARD_OUTPUT_ENABLE_BIT]) begin          // [RULE13]
                next_cur.latch_low  = cur.cfg[LATCH_PIN_LOW_BIT]; // [RULE16]
                next_cur.latch_high = cur.cfg[LATCH_PIN_HIGH_BIT];// [RULE15]
            end else begin
                next_cur.latch_low  = setup.setup_latch_bits[0];  // [RULE20]
                next_cur.latch_high = setup.setup_latch_bits[1];  // [RULE15]
            end
        end

        // Calibration set follows the selected setup
        next_cur.cal_index = cur.cfg[CALIBRATION_SET_SELECT_BIT] ?
            setup.calibration_pointer : setup.channel_pick;       // [RULE17]

        // Rate code and scale bit settle one cycle later
        next_cur.period = rate_period(setup.word_rate,
            cur.cfg[RATE_SCALE_SELECT_BIT]);                      // [RULE18]

        // Power mode sequencing. Standby enters sleep directly;
        // leaving sleep on the internal oscillator always passes
        // through the start-up wait, even towards standby
        case (cur.pwr)
            PWR_NORMAL: begin
                // Kind bit picks the save mode entered
                if (cur.cfg[POWER_DOWN_REQUEST_BIT]) begin        // [RULE2]
                    next_cur.pwr = cur.cfg[POWER_SAVE_KIND_BIT] ?
                        PWR_SLEEP : PWR_STANDBY;
                end
            end
            PWR_STANDBY: begin
                // Oscillator kept alive, so return is immediate
                if (!cur.cfg[POWER_DOWN_REQUEST_BIT]) begin       // [RULE4]
                    next_cur.pwr = PWR_NORMAL;
                end else if (cur.cfg[POWER_SAVE_KIND_BIT]) begin
                    next_cur.pwr = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (!cur.cfg[POWER_DOWN_REQUEST_BIT] ||
                    !cur.cfg[POWER_SAVE_KIND_BIT]) begin
                    // No oscillator to wait for on an external clock
                    if (cur.ext_sync) begin                       // [RULE5]
                        next_cur.pwr = cur.cfg[POWER_DOWN_REQUEST_BIT] ?
                            PWR_STANDBY : PWR_NORMAL;
                    end else begin
                        next_cur.pwr        = PWR_WAKE;
                        next_cur.wake_start = 1'b1;               // [RULE5]
                    end
                end
            end
            PWR_WAKE: begin
                // A new sleep request abandons the start-up wait
                if (cur.cfg[POWER_DOWN_REQUEST_BIT] &&
                    cur.cfg[POWER_SAVE_KIND_BIT]) begin
                    next_cur.pwr = PWR_SLEEP;
                end else if (wake_done) begin                     // [RULE5]
                    next_cur.pwr = cur.cfg[POWER_DOWN_REQUEST_BIT] ?
                        PWR_STANDBY : PWR_NORMAL;
                end
            end
            default: begin
                next_cur.pwr = PWR_NORMAL;
            end
        endcase
    end

    // Asynchronous entry keeps outputs safe before the clock runs
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator start-up wait after sleep; the parameter sets its
    // length so that a short value keeps simulation quick

    osc_startup_timer #(
        .COUNT (OSC_STARTUP)
    ) u_osc_startup_timer (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .start      (cur.wake_start),
        .done       (wake_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Every data output is a register bit or a plain decode
    assign cfg_read_data     = cur.read_data;
    assign power_state       = cur.pwr;
    assign system_reset      = cur.sys_reset;
    assign reset_done_flag   = cur.cfg[RESET_DONE_FLAG_BIT];
    assign command_ready     = !cur.cfg[SYSTEM_RESET_REQUEST_BIT]; // [RULE10]
    assign calibration_index = cur.cal_index;
    assign word_period       = cur.period;                        // [RULE19]

    // Guard mode hands the low pin to the amplifier buffer
    assign latch_pin_low  = cur.latch_low &
                            !cur.cfg[GUARD_OUTPUT_ENABLE_BIT];    // [RULE13]
    // The guard buffer never takes the high pin
    assign latch_pin_high = cur.latch_high;

    // Save modes drop the analog section and filter; only sleep
    // also stops the oscillator and bias generator
    always_comb begin
        analog_ctrl.analog_powered  = (cur.pwr == PWR_NORMAL);    // [RULE3]
        analog_ctrl.filter_run      = (cur.pwr == PWR_NORMAL);    // [RULE3]
        analog_ctrl.oscillator_run  = (cur.pwr != PWR_SLEEP);     // [RULE4]
        analog_ctrl.bias_run        = (cur.pwr != PWR_SLEEP);     // [RULE4]
        analog_ctrl.input_short     = cur.cfg[INPUT_SHORT_BIT];   // [RULE12]
        analog_ctrl.guard_output_enable =
            cur.cfg[GUARD_OUTPUT_ENABLE_BIT];                     // [RULE13]
        analog_ctrl.reference_range_select =
            cur.cfg[REFERENCE_RANGE_SELECT_BIT];                  // [RULE14]
        analog_ctrl.rate_scale_select =
            cur.cfg[RATE_SCALE_SELECT_BIT];                       // [RULE18]
    end

endmodule

`default_nettype wire

/* File: core/adc_cfg_pkg.sv */
package adc_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in the device configuration word
    localparam int unsigned POWER_SAVE_KIND_BIT        = 31;
    localparam int unsigned POWER_DOWN_REQUEST_BIT     = 30;
    localparam int unsigned SYSTEM_RESET_REQUEST_BIT   = 29;
    localparam int unsigned RESET_DONE_FLAG_BIT        = 28;
    localparam int unsigned INPUT_SHORT_BIT            = 27;
    localparam int unsigned GUARD_OUTPUT_ENABLE_BIT    = 26;
    localparam int unsigned REFERENCE_RANGE_SELECT_BIT = 25;
    localparam int unsigned LATCH_PIN_HIGH_BIT         = 24;
    localparam int unsigned LATCH_PIN_LOW_BIT          = 23;
    localparam int unsigned LATCH_SOURCE_SELECT_BIT    = 22;
    localparam int unsigned CALIBRATION_SET_SELECT_BIT = 20;
    localparam int unsigned RATE_SCALE_SELECT_BIT      = 19;

    ////////////////////////////////////////////////////////////////////////
    // Reset values loaded by a system reset
    localparam logic [31:0] CONFIG_RESET        = 32'h00000000;
    localparam logic [31:0] OFFSET_RESET        = 32'h00000000;
    localparam logic [31:0] GAIN_RESET          = 32'h00100000;
    localparam logic [31:0] CHANNEL_SETUP_RESET = 32'h00000000;

    // Bits that a host write may change; flag and reserved bits excluded
    localparam logic [31:0] CONFIG_WRITE_MASK   = 32'hefd80000;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned SYS_CLK_KHZ        = 200000;
    localparam int unsigned OSC_STARTUP_MS     = 20;
    localparam int unsigned OSC_STARTUP_CYCLES = OSC_STARTUP_MS * SYS_CLK_KHZ;

    // Output word period in master clock cycles, fastest rate of each band
    localparam logic [19:0] FAST_PERIOD_NORMAL = 20'h00500;
    localparam logic [19:0] FAST_PERIOD_SCALED = 20'h00600;
    localparam logic [19:0] SLOW_PERIOD_NORMAL = 20'h0a000;
    localparam logic [19:0] SLOW_PERIOD_SCALED = 20'h0c000;
    localparam logic [3:0]  RATE_CODE_SLOW_MAX = 4'h4;
    localparam logic [3:0]  RATE_CODE_FAST_MIN = 4'h8;
    localparam logic [3:0]  RATE_CODE_FAST_MAX = 4'hc;

    ////////////////////////////////////////////////////////////////////////
    // Power state, one-hot
    typedef enum logic [3:0] {
        PWR_NORMAL  = 4'h1,
        PWR_STANDBY = 4'h2,
        PWR_SLEEP   = 4'h4,
        PWR_WAKE    = 4'h8
    } power_state_e;

    // Fields of the selected channel setup, as supplied by the sequencer
    typedef struct packed {
        logic [1:0] channel_pick;
        logic [1:0] calibration_pointer;
        logic [1:0] setup_latch_bits;
        logic [3:0] word_rate;
    } setup_fields_s;

    // Analog and filter controls derived from the configuration
    typedef struct packed {
        logic analog_powered;
        logic filter_run;
        logic oscillator_run;
        logic bias_run;
        logic input_short;
        logic guard_output_enable;
        logic reference_range_select;
        logic rate_scale_select;
    } analog_ctrl_s;

endpackage

/* File: core/osc_startup_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module osc_startup_timer #(
    parameter int unsigned COUNT = 4000000
) (
    input  wire logic sys_clk,
    input  wire logic rst_sync_b,
    input  wire logic start,
    output logic      done
);

    localparam int unsigned W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    typedef struct packed {
        logic [W-1:0] count;
        logic         busy;
        logic         done;
    } timer_state_s;

    timer_state_s cur;
    timer_state_s next_cur;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_cur      = cur;
        next_cur.done = 1'b0;
        if (start) begin
            // A restart during a count begins the full wait again
            next_cur.busy  = 1'b1;
            next_cur.count = '0;
        end else if (cur.busy) begin
            if (cur.count == LAST) begin
                next_cur.busy = 1'b0;
                next_cur.done = 1'b1;
            end else begin
                next_cur.count = cur.count + W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done = cur.done;

endmodule

`default_nettype wire

/* File: bench/adc_config_register_control_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module adc_config_register_control_checker
    import adc_cfg_pkg::*;
#(
    parameter int unsigned OSC_STARTUP = 8
) (
    input wire logic                       sys_clk,
    input wire logic                       rst_b,
    input wire logic                       cfg_write,
    input wire logic [31:0]                cfg_write_data,
    input wire logic                       cfg_read,
    input wire logic [31:0]                cfg_read_data,
    input wire logic                       cmd_execute,
    input wire adc_cfg_pkg::setup_fields_s setup,
    input wire adc_cfg_pkg::power_state_e  power_state,
    input wire adc_cfg_pkg::analog_ctrl_s  analog_ctrl,
    input wire logic                       system_reset,
    input wire logic                       command_ready,
    input wire logic                       reset_done_flag,
    input wire logic                       latch_pin_low,
    input wire logic [19:0]                word_period
);
    logic [1:0]  up_cnt;
    int unsigned wake_cnt;

    // The word period is only trusted once the synchronised reset has let go
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_cnt   <= 2'h0;
            wake_cnt <= 0;
        end else begin
            up_cnt   <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
            wake_cnt <= (power_state == PWR_WAKE) ? wake_cnt + 1 : 0;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////
    a_reset_write: assert property (
        cfg_write && cfg_write_data[29] |=>
        system_reset && reset_done_flag && !command_ready)
        else $error("reset write did not take effect");
    a_reset_pulse: assert property (
        system_reset && !(cfg_write && cfg_write_data[29]) |=> !system_reset)
        else $error("system reset pulse too long");
    a_flag_read: assert property (
        cfg_read && reset_done_flag && !(cfg_write && cfg_write_data[29])
        |=> cfg_read_data[28] && !reset_done_flag)
        else $error("done flag not reported then cleared");
    a_ready_back: assert property (
        cfg_write && !cfg_write_data[29] |=> command_ready)
        else $error("command mode not resumed");
    a_short_follow: assert property (
        cfg_write && !cfg_write_data[29] && command_ready |=>
        analog_ctrl.input_short == $past(cfg_write_data[27]))
        else $error("input short does not follow write");
    a_guard_low: assert property (
        cmd_execute && command_ready && !cfg_write &&
        analog_ctrl.guard_output_enable |=> !latch_pin_low)
        else $error("low pin driven while guard active");
    a_sleep_quiet: assert property (
        power_state == PWR_SLEEP |-> !analog_ctrl.oscillator_run
        && !analog_ctrl.filter_run && !analog_ctrl.analog_powered)
        else $error("sleep leaves oscillator or filter running");
    a_standby_alive: assert property (
        power_state == PWR_STANDBY |-> analog_ctrl.oscillator_run
        && analog_ctrl.bias_run && !analog_ctrl.filter_run)
        else $error("standby state controls wrong");
    a_wake_max: assert property (
        power_state == PWR_WAKE |-> wake_cnt <= OSC_STARTUP + 2)
        else $error("start-up wait too long");
    a_wake_min: assert property (
        power_state == PWR_NORMAL && $past(power_state) == PWR_WAKE
        |-> wake_cnt >= OSC_STARTUP)
        else $error("start-up wait too short");
    a_rate_fast: assert property (
        up_cnt == 2'h3 && setup.word_rate == 4'h8 |=> word_period ==
        ($past(analog_ctrl.rate_scale_select) ? FAST_PERIOD_SCALED
                                              : FAST_PERIOD_NORMAL))
        else $error("fastest word period wrong");
endmodule

bind adc_config_register_control adc_config_register_control_checker #(
    .OSC_STARTUP(OSC_STARTUP)
) u_checker (
    .sys_clk, .rst_b, .cfg_write, .cfg_write_data, .cfg_read,
    .cfg_read_data, .cmd_execute, .setup, .power_state, .analog_ctrl,
    .system_reset, .command_ready, .reset_done_flag, .latch_pin_low,
    .word_period
);

`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module host_model (
    input  wire logic        sys_clk,
    output logic             cfg_write,
    output logic [31:0]      cfg_write_data,
    output logic             cfg_read,
    input  wire logic [31:0] cfg_read_data
);
    initial begin
        cfg_write      = 1'b0;
        cfg_read       = 1'b0;
        cfg_write_data = 32'h0;
    end

    ////////////////////////////////////////////////////////////
    // Whole 32-bit words only; reserved bits always sent as zero
    task automatic write_word(input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        cfg_write      = 1'b1;
        cfg_write_data = d & 32'hffd80000;
        @(posedge sys_clk);
        #1;
        cfg_write      = 1'b0;
        // Idle data is scrambled so nothing can lean on stale bits
        cfg_write_data = ~cfg_write_data;
    endtask

    task automatic read_word(output logic [31:0] d);
        @(posedge sys_clk);
        #1;
        cfg_read = 1'b1;
        @(posedge sys_clk);
        #1;
        cfg_read = 1'b0;
        d        = cfg_read_data;
    endtask
endmodule

`default_nettype wire

/* File: bench/test_adc_config_register_control.sv */
`timescale 1ns/100ps
`default_nettype none

module test_adc_config_register_control;
    import adc_cfg_pkg::*;
    localparam int unsigned OSC = 8;
    logic sys_clk, rst_b, cfg_write, cfg_read, cmd_execute, external_clock;
    logic [31:0] cfg_write_data, cfg_read_data, wr, rd, model_cfg;
    logic system_reset, command_ready, reset_done_flag, model_flag;
    logic latch_pin_low, latch_pin_high, hi, lo;
    logic [1:0] calibration_index;
    logic [19:0] word_period;
    setup_fields_s setup;
    power_state_e power_state;
    analog_ctrl_s analog_ctrl, ac;
    int miscompares, checked, cycles, seed, n;

    host_model u_host_model (.sys_clk, .cfg_write, .cfg_write_data,
        .cfg_read, .cfg_read_data);
    adc_config_register_control #(.OSC_STARTUP(OSC))
    u_adc_config_register_control (.sys_clk, .rst_b, .cfg_write,
        .cfg_write_data, .cfg_read, .cfg_read_data, .cmd_execute, .setup,
        .external_clock, .power_state, .analog_ctrl, .system_reset,
        .command_ready, .reset_done_flag, .latch_pin_low, .latch_pin_high,
        .calibration_index, .word_period);

    ////////////////////////////////////////////////////////////
    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Register model: a reset write keeps only its own bit
    task automatic wcfg(input logic [31:0] d);
        u_host_model.write_word(d);
        if (d[29]) begin
            model_cfg  = 32'h20000000;
            model_flag = 1'b1;
        end else begin
            model_cfg = model_cfg[29] ? 32'h0 : d & CONFIG_WRITE_MASK;
        end
    endtask

    task automatic rcheck();
        u_host_model.read_word(rd);
        check_word("config read", model_cfg | {3'h0, model_flag, 28'h0}, rd);
        model_flag = 1'b0;
    endtask

    task automatic execute();
        cmd_execute = 1'b1;
        @(posedge sys_clk);
        #1;
        cmd_execute = 1'b0;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // Cycles per output word at the master clock
    function automatic logic [19:0] period_of(input int c, input int s);
        int p;
        p = 0;
        if (c <= 4) p = 40960 << c;
        if (c >= 8 && c <= 12) p = 1280 << (c - 8);
        if (s != 0) p = p * 6 / 5;
        return p[19:0];
    endfunction

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        {rst_b, cmd_execute, external_clock, model_flag} = 4'h0;
        {setup, model_cfg, miscompares, checked, cycles} = '0;
        seed = 12415;
        step(6);
        rst_b = 1'b1;
        step(3);
        rcheck();
        check_word("power", PWR_NORMAL, power_state);
        for (int i = 0; i < 16; i++) begin
            wr    = $random(seed) & 32'h1fd80000;
            setup = 10'($random(seed));
            wcfg(wr);
            execute();
            hi = (wr[22] && !wr[26]) ? wr[24] : setup.setup_latch_bits[1];
            lo = wr[26] ? 1'b0 : (wr[22] ? wr[23] : setup.setup_latch_bits[0]);
            check_word("pin high", hi, latch_pin_high);
            check_word("pin low", lo, latch_pin_low);
            check_word("cal index", wr[20] ? setup.calibration_pointer
                       : setup.channel_pick, calibration_index);
            ac = '{1'b1, 1'b1, 1'b1, 1'b1, wr[27], wr[26], wr[25], wr[19]};
            check_word("analog", ac, analog_ctrl);
            rcheck();
        end
        for (int s = 0; s < 2; s++) begin
            wcfg(s != 0 ? 32'h00080000 : 32'h0);
            for (int c = 0; c < 16; c++) begin
                setup.word_rate = c[3:0];
                step(2);
                check_word("period", period_of(c, s), word_period);
            end
        end
        wcfg(32'h01400000);
        execute();
        wcfg(32'hffffffff);
        check_word("ready", 1'b0, command_ready);
        check_word("flag", 1'b1, reset_done_flag);
        check_word("sys reset", 1'b1, system_reset);
        check_word("analog", 8'hf0, analog_ctrl);
        setup.setup_latch_bits = 2'h3;
        execute();
        check_word("pins", 2'h0, {latch_pin_high, latch_pin_low});
        check_word("sys reset", 1'b0, system_reset);
        wcfg(32'h08000000);
        check_word("ready", 1'b1, command_ready);
        rcheck();
        rcheck();
        wcfg(32'h40000000);
        step(1);
        check_word("power", PWR_STANDBY, power_state);
        check_word("analog", 8'h30, analog_ctrl);
        wcfg(32'h0);
        step(1);
        check_word("power", PWR_NORMAL, power_state);
        for (int e = 0; e < 2; e++) begin
            external_clock = e[0];
            wcfg(32'hc0000000);
            step(1);
            check_word("power", PWR_SLEEP, power_state);
            check_word("analog", 8'h00, analog_ctrl);
            wcfg(32'h0);
            n = 0;
            while (power_state !== PWR_NORMAL && n < 100) begin
                step(1);
                n++;
            end
            check_word("wake ok", 1'b1, e != 0 ? n == 1
                       : n >= OSC && n <= OSC + 3);
        end
        stop_test();
    end
endmodule

`default_nettype wire
